// ### design/ebws_top.sv
`timescale 1ns/1ps
// Functional notes
// R1: in hold, grant high and bus floated
// R2: two-plus waits: wait_phase_done_n low first wait
// R3: wait_phase_done_n high at last software wait
// R4: looped to ready, exactly one extra wait
// R5: fetch_addr_flag_n low during instruction address cycles
// R6: output-off low floats the three status pins
// R7: ready low: wait a cycle, sample again
// R8: ready checked only after two-plus waits complete
// R9: external master holds request until finished
// R10: finish access, grant; release one cycle later
module ebws_top (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic ACC_REQ,
  input wire ebws_pkg::ebws_cmd_t ACC_CMD,
  input wire logic READY,
  input wire logic HOLD_REQ,
  input wire logic OFF_N,
  output logic HOLD_GRANT_OUT,
  output logic HOLD_GRANT_OE,
  output logic WAIT_PHASE_DONE_N,
  output logic WAIT_PHASE_DONE_OE,
  output logic FETCH_ADDR_FLAG_N,
  output logic FETCH_ADDR_FLAG_OE,
  output logic BUS_DRIVE_EN,
  output logic BUS_IDLE,
  output logic ACC_DONE
);

  // =====================================================================
  // state
  // =====================================================================
  ebws_pkg::ebws_state_t state_q;
  ebws_pkg::ebws_state_t state_d;
  logic [ebws_pkg::WAIT_W-1:0] cnt_q;
  logic [ebws_pkg::WAIT_W-1:0] cnt_d;
  logic fetch_q;
  logic fetch_d;
  logic multi_q;
  logic multi_d;
  logic ready_q;
  logic ready_d;
  logic grant_q;
  logic grant_d;
  logic wait_n_q;
  logic wait_n_d;
  logic fetch_n_q;
  logic fetch_n_d;
  logic oe_q;
  logic oe_d;
  logic drive_q;
  logic drive_d;
  logic idle_q;
  logic idle_d;
  logic done_q;
  logic done_d;

  // =====================================================================
  // pin sampling
  // =====================================================================
  // ready is registered, so a decision sees the pin one cycle late; this
  // is what makes a looped-back wait_phase_done_n cost exactly one cycle
  always_comb begin
    ready_d = READY;
    oe_d = OFF_N; // [R6]
  end

  // =====================================================================
  // bus sequencer
  // =====================================================================
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    fetch_d = fetch_q;
    multi_d = multi_q;
    done_d = 1'h0;
    case (state_q)
      ebws_pkg::ST_IDLE: begin
        // hold is only granted from idle, so a running access always ends first
        if (HOLD_REQ) begin
          state_d = ebws_pkg::ST_HOLD; // [R10]
        end else if (ACC_REQ) begin
          state_d = ebws_pkg::ST_ADDR;
          fetch_d = ACC_CMD.fetch;
          cnt_d = ACC_CMD.sw_waits;
          multi_d = (ACC_CMD.sw_waits >= ebws_pkg::WAIT_READY_MIN); // [R8]
        end
      end
      ebws_pkg::ST_ADDR: begin
        if (cnt_q == ebws_pkg::WAIT_NONE) begin
          state_d = ebws_pkg::ST_IDLE;
          done_d = 1'h1;
        end else begin
          state_d = ebws_pkg::ST_SWWAIT;
        end
      end
      ebws_pkg::ST_SWWAIT: begin
        if (cnt_q == ebws_pkg::WAIT_LAST) begin
          // ready only counts once the programmed waits are over
          if (multi_q && !ready_q) begin
            state_d = ebws_pkg::ST_RDYWAIT; // [R8] [R4]
          end else begin
            state_d = ebws_pkg::ST_IDLE;
            done_d = 1'h1;
          end
        end else begin
          cnt_d = cnt_q - ebws_pkg::WAIT_LAST;
        end
      end
      ebws_pkg::ST_RDYWAIT: begin
        // stays one more cycle per low sample
        if (ready_q) begin
          state_d = ebws_pkg::ST_IDLE; // [R7]
          done_d = 1'h1;
        end
      end
      ebws_pkg::ST_HOLD: begin
        // the far master keeps its request up for the whole use of the bus
        if (!HOLD_REQ) begin
          state_d = ebws_pkg::ST_IDLE; // [R10] [R9]
        end
      end
      default: begin
        state_d = ebws_pkg::ST_IDLE;
      end
    endcase
  end

  // =====================================================================
  // status outputs, decoded from the next state so pins line up with it
  // =====================================================================
  always_comb begin
    grant_d = 1'h0;
    drive_d = 1'h1;
    idle_d = 1'h0;
    wait_n_d = 1'h1;
    fetch_n_d = 1'h1;
    case (state_d)
      ebws_pkg::ST_IDLE: begin
        idle_d = 1'h1;
      end
      ebws_pkg::ST_ADDR: begin
        // the fetch address stays on the bus through every wait
        fetch_n_d = !fetch_d; // [R5]
      end
      ebws_pkg::ST_SWWAIT: begin
        fetch_n_d = !fetch_d; // [R5]
        // low from the first wait; back high when only the last remains
        if (multi_d) begin
          wait_n_d = (cnt_d == ebws_pkg::WAIT_LAST); // [R2] [R3]
        end
      end
      ebws_pkg::ST_RDYWAIT: begin
        // wait flag stays high here, so a looped-back flag frees ready at once
        fetch_n_d = !fetch_d; // [R5] [R4]
      end
      ebws_pkg::ST_HOLD: begin
        grant_d = 1'h1; // [R1]
        drive_d = 1'h0; // [R1] [R10]
      end
      default: begin
        idle_d = 1'h1;
      end
    endcase
  end

  // =====================================================================
  // registers
  // =====================================================================
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      ready_q <= ebws_pkg::RST_READY;
      oe_q <= ebws_pkg::RST_OE;
    end else begin
      ready_q <= ready_d;
      oe_q <= oe_d;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_q <= ebws_pkg::ST_IDLE;
      cnt_q <= ebws_pkg::WAIT_NONE;
      fetch_q <= 1'h0;
      multi_q <= 1'h0;
      done_q <= ebws_pkg::RST_DONE;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      fetch_q <= fetch_d;
      multi_q <= multi_d;
      done_q <= done_d;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      grant_q <= ebws_pkg::RST_GRANT;
      wait_n_q <= ebws_pkg::RST_WAIT_N;
      fetch_n_q <= ebws_pkg::RST_FETCH_N;
      drive_q <= ebws_pkg::RST_DRIVE;
      idle_q <= ebws_pkg::RST_IDLE;
    end else begin
      grant_q <= grant_d;
      wait_n_q <= wait_n_d;
      fetch_n_q <= fetch_n_d;
      drive_q <= drive_d;
      idle_q <= idle_d;
    end
  end

  // =====================================================================
  // ports
  // =====================================================================
  // one shared enable: the off pin floats all three status pins alike
  always_comb begin
    HOLD_GRANT_OUT = grant_q;
    HOLD_GRANT_OE = oe_q; // [R6]
    WAIT_PHASE_DONE_N = wait_n_q;
    WAIT_PHASE_DONE_OE = oe_q; // [R6]
    FETCH_ADDR_FLAG_N = fetch_n_q;
    FETCH_ADDR_FLAG_OE = oe_q; // [R6]
    BUS_DRIVE_EN = drive_q;
    BUS_IDLE = idle_q;
    ACC_DONE = done_q;
  end

endmodule // ebws_top

// ### design/ebws_pkg.sv
package ebws_pkg;

  // =====================================================================
  // access command layout
  // =====================================================================
  localparam int unsigned WAIT_W = 3;
  localparam logic [WAIT_W-1:0] WAIT_NONE = 3'h0;
  localparam logic [WAIT_W-1:0] WAIT_LAST = 3'h1;
  localparam logic [WAIT_W-1:0] WAIT_READY_MIN = 3'h2;

  typedef struct packed {
    logic fetch;
    logic [WAIT_W-1:0] sw_waits;
  } ebws_cmd_t;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic RST_GRANT = 1'h0;
  localparam logic RST_WAIT_N = 1'h1;
  localparam logic RST_FETCH_N = 1'h1;
  localparam logic RST_OE = 1'h0;
  localparam logic RST_DRIVE = 1'h1;
  localparam logic RST_IDLE = 1'h1;
  localparam logic RST_DONE = 1'h0;
  localparam logic RST_READY = 1'h1;

  // =====================================================================
  // sequencer states
  // =====================================================================
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SWWAIT,
    ST_RDYWAIT,
    ST_HOLD
  } ebws_state_t;

endpackage

// ### bench/ebws_assertions.sv
`timescale 1ns/1ps
module ebws_checker (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic ACC_REQ,
  input wire ebws_pkg::ebws_cmd_t ACC_CMD,
  input wire logic READY,
  input wire logic HOLD_REQ,
  input wire logic OFF_N,
  input wire logic HOLD_GRANT_OUT,
  input wire logic HOLD_GRANT_OE,
  input wire logic WAIT_PHASE_DONE_N,
  input wire logic WAIT_PHASE_DONE_OE,
  input wire logic FETCH_ADDR_FLAG_N,
  input wire logic FETCH_ADDR_FLAG_OE,
  input wire logic BUS_DRIVE_EN,
  input wire logic BUS_IDLE,
  input wire logic ACC_DONE
);
  // ====
  // access tracking
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic take;
  logic f_q, f_d;
  logic [2:0] n_q, n_d;
  logic [4:0] c_q, c_d;
  always_comb begin
    take = ACC_REQ && BUS_IDLE && !HOLD_REQ;
    n_d = take ? ACC_CMD.sw_waits : n_q;
    f_d = take ? ACC_CMD.fetch : f_q;
    c_d = take ? 5'h1 : c_q + {4'h0, !BUS_IDLE};
  end
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      n_q <= 3'h0;
      f_q <= 1'h0;
      c_q <= 5'h0;
    end else begin
      n_q <= n_d;
      f_q <= f_d;
      c_q <= c_d;
    end
  end
  // ====
  // checks
  hold_float_a: assert property (HOLD_GRANT_OUT |-> !BUS_DRIVE_EN && !BUS_IDLE)
    else $error("bus driven in hold");
  wait_low_a: assert property (take && ACC_CMD.sw_waits >= 3'h2 |-> ##2 !WAIT_PHASE_DONE_N)
    else $error("wait flag late");
  wait_only_a: assert property (!WAIT_PHASE_DONE_N |-> n_q >= 3'h2 && !BUS_IDLE)
    else $error("wait flag spurious");
  wait_high_a: assert property ($rose(WAIT_PHASE_DONE_N) && !BUS_IDLE |-> c_q == {2'h0, n_q} + 5'h1)
    else $error("wait flag rise wrong");
  ready_gate_a: assert property (ACC_DONE && n_q >= 3'h2 |-> $past(READY, 2) && c_q >= {2'h0, n_q} + 5'h2)
    else $error("ready not honoured");
  done_time_a: assert property (ACC_DONE && n_q < 3'h2 |-> c_q == {2'h0, n_q} + 5'h2)
    else $error("short access latency");
  fetch_flag_a: assert property (FETCH_ADDR_FLAG_N == !(f_q && !BUS_IDLE && !HOLD_GRANT_OUT))
    else $error("fetch flag wrong");
  off_float_a: assert property (!$past(RESET) |->
    {HOLD_GRANT_OE, WAIT_PHASE_DONE_OE, FETCH_ADDR_FLAG_OE} == {3{$past(OFF_N)}})
    else $error("enable mismatch");
  hold_grant_a: assert property (HOLD_REQ && BUS_IDLE && !HOLD_GRANT_OUT |=> HOLD_GRANT_OUT)
    else $error("grant late");
  hold_release_a: assert property (HOLD_GRANT_OUT && !HOLD_REQ |=> !HOLD_GRANT_OUT && BUS_DRIVE_EN)
    else $error("release late");
  cover property (take && ACC_CMD.sw_waits == 3'h3);
  cover property ($rose(HOLD_GRANT_OUT));
  cover property (HOLD_REQ && !BUS_IDLE && !HOLD_GRANT_OUT);
  cover property (ACC_DONE && c_q > {2'h0, n_q} + 5'h2);
endmodule // ebws_checker
bind ebws_top ebws_checker chk_i (.*);

// ### bench/ebws_partner.sv
`timescale 1ns/1ps
module ebws_partner (
  input wire logic loop,
  input wire logic stall,
  input wire logic done_n,
  output logic ready
);
  // loop wiring costs one extra wait; stall models a slow memory
  assign ready = loop ? done_n : !stall;
endmodule // ebws_partner

// ### bench/ebws_tb_top.sv
`timescale 1ns/1ps
module ebws_tb_top;
  logic clk = 1'h0, rst = 1'h1, acc_req = 1'h0, hold = 1'h0, off_n = 1'h1, loop = 1'h0, stall = 1'h0;
  logic rdy, grant, g_oe, wpd_n, w_oe, faf_n, f_oe, drv, idle, done;
  ebws_pkg::ebws_cmd_t cmd = 4'h0;
  int fail_count = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  ebws_top DUT (.CORE_CLK(clk), .RESET(rst), .ACC_REQ(acc_req), .ACC_CMD(cmd), .READY(rdy), .HOLD_REQ(hold),
    .OFF_N(off_n), .HOLD_GRANT_OUT(grant), .HOLD_GRANT_OE(g_oe), .WAIT_PHASE_DONE_N(wpd_n),
    .WAIT_PHASE_DONE_OE(w_oe), .FETCH_ADDR_FLAG_N(faf_n), .FETCH_ADDR_FLAG_OE(f_oe), .BUS_DRIVE_EN(drv),
    .BUS_IDLE(idle), .ACC_DONE(done));
  ebws_partner mem (.loop(loop), .stall(stall), .done_n(wpd_n), .ready(rdy));
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s exp %h got %h", s, e, g);
      fail_count++;
    end
  endtask
  task summarize;
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one access from an idle negedge; returns in the done cycle
  task acc(input logic f, input logic [2:0] n, input logic [7:0] e, input logic [7:0] rel);
    logic [7:0] c;
    acc_req = 1'h1;
    cmd = {f, n};
    @(negedge clk);
    acc_req = 1'h0;
    c = 8'h1;
    chk("fetch_flag", {7'h0, !f}, {7'h0, faf_n});
    while (done !== 1'h1 && c < 8'h28) begin
      @(negedge clk);
      c++;
      if (c == rel) stall = 1'h0;
      if (c == 8'h2) chk("wait_low", {7'h0, n < 3'h2}, {7'h0, wpd_n});
      if (n >= 3'h2 && c == {5'h0, n} + 8'h1) chk("wait_high", 8'h1, {7'h0, wpd_n});
    end
    chk("latency", e, c);
  endtask
  task t_waits;
    for (int n = 0; n < 5; n++) acc(n[0], n[2:0], n[7:0] + 8'h2, 8'h0);
  endtask
  task t_ready;
    loop = 1'h1;
    acc(1'h1, 3'h3, 8'h6, 8'h0);
    loop = 1'h0;
    stall = 1'h1;
    acc(1'h0, 3'h1, 8'h3, 8'h0);
    acc(1'h1, 3'h2, 8'h7, 8'h5);
    stall = 1'h0;
  endtask
  task t_hold;
    acc_req = 1'h1;
    cmd = {1'h0, 3'h2};
    @(negedge clk);
    acc_req = 1'h0;
    hold = 1'h1;
    repeat (2) @(negedge clk);
    chk("busy_grant", 8'h1, {6'h0, grant, drv});
    @(negedge clk);
    chk("busy_done", 8'h1, {6'h0, grant, done});
    @(negedge clk);
    chk("grant_drive", 8'h2, {6'h0, grant, drv});
    acc_req = 1'h1;
    @(negedge clk);
    acc_req = 1'h0;
    hold = 1'h0;
    @(negedge clk);
    chk("release", 8'h3, {5'h0, grant, drv, idle});
  endtask
  task t_off;
    off_n = 1'h0;
    @(negedge clk);
    chk("oe_off", 8'h0, {5'h0, g_oe, w_oe, f_oe});
    off_n = 1'h1;
    @(negedge clk);
    chk("oe_on", 8'h7, {5'h0, g_oe, w_oe, f_oe});
  endtask
  initial begin
    #2000;
    fail_count++;
    summarize;
  end
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'h0;
    t_waits;
    t_ready;
    t_hold;
    t_off;
    summarize;
  end
endmodule // ebws_tb_top
